// file: design/csc_sys_ctrl.sv
// converter system control register with reference scaling and protection modes
// assumes a serial engine delivers decoded byte writes and reads on the register port
`timescale 1ns/1ps
`default_nettype none
module csc_sys_ctrl import csc_pkg::*; (
  // clock, reset, enable
  input  wire logic       I_CLOCK,
  input  wire logic       I_SRST,
  input  wire logic       I_CE,
  // external enable pin
  input  wire logic       I_EXT_EN,
  // register port from the serial engine
  input  wire logic [7:0] I_REG_ADDR,
  input  wire logic [7:0] I_REG_WDATA,
  input  wire logic       I_REG_WR,
  input  wire logic       I_REG_RD,
  output logic      [7:0] O_REG_RDATA,
  output logic            O_SERIAL_ON,
  // fault detectors
  input  wire logic       I_OVERVOLTAGE_PROTECT,
  input  wire logic       I_OVERCURRENT_PROTECT,
  input  wire logic       I_UNDERVOLTAGE_DETECT,
  // power stage control
  output logic            O_HIGH_SIDE_SWITCH_EN,
  output logic            O_LOW_SIDE_SWITCH_EN,
  output logic            O_FORCED_PWM,
  output logic      [6:0] O_REF_TARGET,
  output logic            O_HICCUP,
  output logic            O_LATCHED_OFF
);

  // ************************************************************
  // register state
  // ************************************************************
  // host written control fields, go among them
  logic       sw_en_reg;
  logic       sw_en_next;
  logic       go_reg;
  logic       go_next;
  logic [2:0] slew_reg;
  logic [2:0] slew_next;
  logic       ovp_retry_reg;
  logic       ovp_retry_next;
  logic       ocp_hiccup_reg;
  logic       ocp_hiccup_next;
  logic       mode_reg;
  logic       mode_next;

  // reference code and its ramp bookkeeping
  logic [6:0] ref_code_reg;
  logic [6:0] ref_code_next;
  logic       pending_reg;
  logic       pending_next;

  // registered read data
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // decoded strobes and ramp hookup
  logic       serial_on;
  logic       wr_ref;
  logic       wr_ctrl;
  logic       ref_accept;
  logic [8:0] step_period;
  logic [6:0] ramp_code;
  logic       ramp_at_goal;
  logic [7:0] ctrl_view;

  // the serial port only lives while the external enable is high
  assign serial_on  = I_EXT_EN;
  assign wr_ref     = serial_on && I_REG_WR && (I_REG_ADDR == REF_SELECT_ADDR);
  assign wr_ctrl    = serial_on && I_REG_WR && (I_REG_ADDR == SYS_CTRL1_ADDR);
  // writes to the reference without authority are dropped whole
  assign ref_accept = wr_ref && go_reg;

  // go is read live, the other fields as last written
  assign ctrl_view = {sw_en_reg, go_reg, slew_reg, ovp_retry_reg, ocp_hiccup_reg, mode_reg};

  // ************************************************************
  // control fields
  // ************************************************************
  // enable low restores every default, like a fresh start-up
  always_comb begin
    sw_en_next      = sw_en_reg;
    slew_next       = slew_reg;
    ovp_retry_next  = ovp_retry_reg;
    ocp_hiccup_next = ocp_hiccup_reg;
    mode_next       = mode_reg;
    if (!I_EXT_EN) begin
      sw_en_next      = SW_EN_RST;
      slew_next       = SLEW_RST;
      ovp_retry_next  = OVP_RETRY_RST;
      ocp_hiccup_next = OCP_HICCUP_RST;
      mode_next       = MODE_RST;
    end else if (wr_ctrl) begin
      sw_en_next      = I_REG_WDATA[SW_EN_BIT];
      slew_next       = I_REG_WDATA[SLEW_MSB:SLEW_LSB];
      ovp_retry_next  = I_REG_WDATA[OVP_RETRY_BIT];
      ocp_hiccup_next = I_REG_WDATA[OCP_HICCUP_BIT];
      mode_next       = I_REG_WDATA[MODE_BIT];
    end
  end

  // control registers, frozen while the clock enable is low
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      sw_en_reg      <= SW_EN_RST;
      slew_reg       <= SLEW_RST;
      ovp_retry_reg  <= OVP_RETRY_RST;
      ocp_hiccup_reg <= OCP_HICCUP_RST;
      mode_reg       <= MODE_RST;
    end else if (I_CE) begin
      sw_en_reg      <= sw_en_next;
      slew_reg       <= slew_next;
      ovp_retry_reg  <= ovp_retry_next;
      ocp_hiccup_reg <= ocp_hiccup_next;
      mode_reg       <= mode_next;
    end
  end

  // ************************************************************
  // scaling authority and reference code
  // ************************************************************
  // a host set of go wins over the automatic clear in the same cycle
  always_comb begin
    go_next       = go_reg;
    ref_code_next = ref_code_reg;
    pending_next  = pending_reg;
    if (!I_EXT_EN) begin
      go_next       = GO_RST;
      ref_code_next = REF_CODE_RST;
      pending_next  = 1'b0;
    end else begin
      if (ref_accept) begin
        ref_code_next = I_REG_WDATA[6:0];
        pending_next  = 1'b1;
      end else if (pending_reg && ramp_at_goal) begin
        // pending stops a match on the old goal from clearing go early
        go_next      = 1'b0;
        pending_next = 1'b0;
      end
      if (wr_ctrl) begin
        go_next = I_REG_WDATA[GO_BIT_POS];
      end
    end
  end

  // scaling registers, frozen while the clock enable is low
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      go_reg       <= GO_RST;
      ref_code_reg <= REF_CODE_RST;
      pending_reg  <= 1'b0;
    end else if (I_CE) begin
      go_reg       <= go_next;
      ref_code_reg <= ref_code_next;
      pending_reg  <= pending_next;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  // read data is registered and holds until the next read, or clears to zero while the enable pin is low
  always_comb begin
    rdata_next = rdata_reg;
    if (!I_EXT_EN) begin
      rdata_next = 8'h00;
    end else if (I_REG_RD) begin
      // go shows the live ramp status, so polling sees it drop
      unique case (I_REG_ADDR)
        REF_SELECT_ADDR: rdata_next = {1'b0, ref_code_reg};
        SYS_CTRL1_ADDR:  rdata_next = ctrl_view;
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      rdata_reg <= 8'h00;
    end else if (I_CE) begin
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // slew selection and reference ramp
  // ************************************************************
  // 30 mV/us rounds down to whole cycles, so it runs slightly fast
  always_comb begin
    unique case (slew_reg)
      3'h0: step_period = STEP_CYC_0;
      3'h1: step_period = STEP_CYC_1;
      3'h2: step_period = STEP_CYC_2;
      3'h3: step_period = STEP_CYC_3;
      3'h4: step_period = STEP_CYC_4;
      3'h5: step_period = STEP_CYC_5;
      3'h6: step_period = STEP_CYC_6;
      3'h7: step_period = STEP_CYC_7;
    endcase
  end

  // the ramp falls back to the reset code whenever the enable pin drops
  csc_ramp u_ramp (
    .i_clock   (I_CLOCK),
    .i_srst    (I_SRST),
    .i_ce      (I_CE),
    .i_clear   (!I_EXT_EN),
    .i_goal    (ref_code_reg),
    .i_period  (step_period),
    .o_code    (ramp_code),
    .o_at_goal (ramp_at_goal)
  );

  // ************************************************************
  // protection state
  // ************************************************************
  // protection state and hiccup off timer
  csc_prot_e   prot_reg;
  csc_prot_e   prot_next;
  logic [11:0] hic_cnt_reg;
  logic [11:0] hic_cnt_next;

  // a latch only clears by dropping the enable pin or a full reset
  always_comb begin
    prot_next    = prot_reg;
    hic_cnt_next = hic_cnt_reg;
    if (!I_EXT_EN) begin
      prot_next    = PROT_RUN;
      hic_cnt_next = 12'h000;
    end else begin
      unique case (prot_reg)
        PROT_RUN: begin
          if (I_OVERCURRENT_PROTECT && I_UNDERVOLTAGE_DETECT) begin
            prot_next    = ocp_hiccup_reg ? PROT_HICCUP : PROT_LATCH;
            hic_cnt_next = 12'h000;
          end else if (I_OVERVOLTAGE_PROTECT && !ovp_retry_reg) begin
            prot_next = PROT_LATCH;
          end
        end
        PROT_HICCUP: begin
          if (hic_cnt_reg + 12'h001 >= HICCUP_CYC) begin
            prot_next    = PROT_RUN;
            hic_cnt_next = 12'h000;
          end else begin
            hic_cnt_next = hic_cnt_reg + 12'h001;
          end
        end
        PROT_LATCH: prot_next = PROT_LATCH;
        default: prot_next = PROT_RUN;
      endcase
    end
  end

  // protection registers, frozen with the rest of the state
  always_ff @(posedge I_CLOCK) begin
    if (I_SRST) begin
      prot_reg    <= PROT_RUN;
      hic_cnt_reg <= 12'h000;
    end else if (I_CE) begin
      prot_reg    <= prot_next;
      hic_cnt_reg <= hic_cnt_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // with retry set, an overvoltage only pauses switching while it lasts
  logic switching;
  assign switching = I_EXT_EN && sw_en_reg && (prot_reg == PROT_RUN)
                     && !I_OVERVOLTAGE_PROTECT;

  // both switches share one gate; dead time is left to the power stage
  assign O_HIGH_SIDE_SWITCH_EN = switching;
  assign O_LOW_SIDE_SWITCH_EN  = switching;
  assign O_FORCED_PWM          = go_reg || mode_reg;
  assign O_REF_TARGET          = ramp_code;
  assign O_HICCUP              = (prot_reg == PROT_HICCUP);
  assign O_LATCHED_OFF         = (prot_reg == PROT_LATCH);
  assign O_REG_RDATA           = rdata_reg;
  assign O_SERIAL_ON           = serial_on;

endmodule
`default_nettype wire

// file: design/csc_pkg.sv
// constants shared by the converter system control block
// assumes a 40 MHz core clock and a byte-wide register port fed by a serial engine
package csc_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] REF_SELECT_ADDR = 8'h00;  // reference_select
  localparam logic [7:0] SYS_CTRL1_ADDR  = 8'h01;  // system_control_one

  // field positions in system_control_one
  localparam int SW_EN_BIT      = 7;
  localparam int GO_BIT_POS     = 6;
  localparam int SLEW_MSB       = 5;
  localparam int SLEW_LSB       = 3;
  localparam int OVP_RETRY_BIT  = 2;
  localparam int OCP_HICCUP_BIT = 1;
  localparam int MODE_BIT       = 0;

  // reset values
  localparam logic       SW_EN_RST      = 1'b1;
  localparam logic       GO_RST         = 1'b0;
  localparam logic [2:0] SLEW_RST       = 3'h4;
  localparam logic       OVP_RETRY_RST  = 1'b1;
  localparam logic       OCP_HICCUP_RST = 1'b1;
  localparam logic       MODE_RST       = 1'b0;
  localparam logic [6:0] REF_CODE_RST   = 7'h1E;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 25;
  // time for one 4 mV reference step at each slew setting
  localparam int STEP_NS_0 = 100;   // 40 mV/us
  localparam int STEP_NS_1 = 133;   // 30 mV/us
  localparam int STEP_NS_2 = 200;   // 20 mV/us
  localparam int STEP_NS_3 = 400;   // 10 mV/us
  localparam int STEP_NS_4 = 800;   // 5 mV/us
  localparam int STEP_NS_5 = 1600;  // 2.5 mV/us
  localparam int STEP_NS_6 = 3200;  // 1.25 mV/us
  localparam int STEP_NS_7 = 6400;  // 0.625 mV/us
  localparam logic [8:0] STEP_CYC_0 = 9'(STEP_NS_0 / CLK_PERIOD_NS);
  localparam logic [8:0] STEP_CYC_1 = 9'(STEP_NS_1 / CLK_PERIOD_NS);
  localparam logic [8:0] STEP_CYC_2 = 9'(STEP_NS_2 / CLK_PERIOD_NS);
  localparam logic [8:0] STEP_CYC_3 = 9'(STEP_NS_3 / CLK_PERIOD_NS);
  localparam logic [8:0] STEP_CYC_4 = 9'(STEP_NS_4 / CLK_PERIOD_NS);
  localparam logic [8:0] STEP_CYC_5 = 9'(STEP_NS_5 / CLK_PERIOD_NS);
  localparam logic [8:0] STEP_CYC_6 = 9'(STEP_NS_6 / CLK_PERIOD_NS);
  localparam logic [8:0] STEP_CYC_7 = 9'(STEP_NS_7 / CLK_PERIOD_NS);

  // hiccup off time before a restart attempt
  localparam int          HICCUP_US  = 100;
  localparam logic [11:0] HICCUP_CYC = 12'(HICCUP_US * 1000 / CLK_PERIOD_NS);

  // protection states
  typedef enum logic [2:0] {
    PROT_RUN    = 3'b001,
    PROT_HICCUP = 3'b010,
    PROT_LATCH  = 3'b100
  } csc_prot_e;

endpackage

// file: design/csc_ramp.sv
// linear reference ramp: walks the output code one step per period toward the goal
// assumes the period input is at least one cycle and stable during a step
`timescale 1ns/1ps
`default_nettype none
module csc_ramp import csc_pkg::*; (
  // clock and control
  input  wire logic       i_clock,
  input  wire logic       i_srst,
  input  wire logic       i_ce,
  input  wire logic       i_clear,
  // ramp request
  input  wire logic [6:0] i_goal,
  input  wire logic [8:0] i_period,
  // ramp state
  output logic      [6:0] o_code,
  output logic            o_at_goal
);

  logic [6:0] code_reg;
  logic [6:0] code_next;
  logic [8:0] cnt_reg;
  logic [8:0] cnt_next;

  // ************************************************************
  // step timing
  // ************************************************************
  // one code per period, so a change never jumps the target
  always_comb begin
    code_next = code_reg;
    cnt_next  = cnt_reg;
    if (i_clear) begin
      code_next = REF_CODE_RST;
      cnt_next  = 9'h000;
    end else if (code_reg == i_goal) begin
      cnt_next = 9'h000;
    end else if (cnt_reg + 9'h001 >= i_period) begin
      cnt_next = 9'h000;
      if (code_reg < i_goal) begin
        code_next = code_reg + 7'h01;
      end else begin
        code_next = code_reg - 7'h01;
      end
    end else begin
      cnt_next = cnt_reg + 9'h001;
    end
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      code_reg <= REF_CODE_RST;
      cnt_reg  <= 9'h000;
    end else if (i_ce) begin
      code_reg <= code_next;
      cnt_reg  <= cnt_next;
    end
  end

  assign o_code    = code_reg;
  assign o_at_goal = (code_reg == i_goal);

endmodule
`default_nettype wire

// file: design/_unused_placeholder_never.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: bench/csc_sys_ctrl_chk.sv
// port checker for the system control block
// assumes bind into csc_sys_ctrl; register checks except a_ref_refused count only clock-enabled edges
`timescale 1ns/1ps
`default_nettype none
module csc_chk import csc_pkg::*; (
  // clock and pins
  input wire logic       I_CLOCK,
  input wire logic       I_SRST,
  input wire logic       I_CE,
  input wire logic       I_EXT_EN,
  input wire logic       I_OVERVOLTAGE_PROTECT,
  // register port
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic       I_REG_WR,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic       O_SERIAL_ON,
  // power stage
  input wire logic       O_HIGH_SIDE_SWITCH_EN,
  input wire logic       O_LOW_SIDE_SWITCH_EN,
  input wire logic       O_FORCED_PWM,
  input wire logic [6:0] O_REF_TARGET,
  input wire logic       O_HICCUP,
  input wire logic       O_LATCHED_OFF
);
  // ****************
  // helpers
  // ****************
  logic        wr01;
  logic        sw_on;
  logic [11:0] hic_cnt_reg;
  logic [11:0] hic_cnt_next;
  assign wr01  = I_CE && I_EXT_EN && I_REG_WR && I_REG_ADDR == SYS_CTRL1_ADDR;
  assign sw_on = O_HIGH_SIDE_SWITCH_EN || O_LOW_SIDE_SWITCH_EN;
  // hiccup length; reset folded in so the flop stays plain
  // a frozen clock enable also freezes the design's off timer
  always_comb hic_cnt_next = (I_SRST || !O_HICCUP) ? 12'h000
                             : (I_CE ? hic_cnt_reg + 12'h001 : hic_cnt_reg);
  always_ff @(posedge I_CLOCK) hic_cnt_reg <= hic_cnt_next;
  // ****************
  // properties
  // ****************
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  a_serial_gate: assert property (O_SERIAL_ON == I_EXT_EN)
    else $error("serial port state wrong");
  a_switch_gate: assert property (sw_on |-> I_EXT_EN && !I_OVERVOLTAGE_PROTECT
    && !O_HICCUP && !O_LATCHED_OFF) else $error("switching while off");
  a_off_clear: assert property (I_CE && !I_EXT_EN |=> O_REG_RDATA == 8'h00
    && O_REF_TARGET == REF_CODE_RST && !O_LATCHED_OFF) else $error("not cleared");
  a_sw_bit_off: assert property (wr01 && !I_REG_WDATA[SW_EN_BIT] |=> !sw_on)
    else $error("switching with enable bit clear");
  a_pwm_follow: assert property (wr01 |=>
    O_FORCED_PWM == (($past(I_REG_WDATA) & 8'h41) != 8'h00)) else $error("pwm mode wrong");
  a_ref_refused: assert property (I_EXT_EN && I_REG_WR && I_REG_ADDR == REF_SELECT_ADDR
    && !O_FORCED_PWM |=> ($stable(O_REF_TARGET) || !$past(I_EXT_EN)) [*4])
    else $error("refused write moved target");
  a_ramp_step: assert property (!$past(I_SRST) && $past(I_EXT_EN) && $changed(O_REF_TARGET)
    |-> O_REF_TARGET - $past(O_REF_TARGET) == 7'h01
    || $past(O_REF_TARGET) - O_REF_TARGET == 7'h01) else $error("target jumped");
  a_hiccup_len: assert property ($fell(O_HICCUP) && $past(I_EXT_EN) && !$past(I_SRST)
    |-> hic_cnt_reg == HICCUP_CYC) else $error("hiccup length wrong");
  cover property ($rose(O_HICCUP));
  cover property ($rose(O_LATCHED_OFF));
  cover property ($changed(O_REF_TARGET));
endmodule
`default_nettype wire

// file: bench/csc_host.sv
// host model driving the byte register port
// assumes strobes taken on rising edges, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
module csc_host (
  // clock
  input  wire logic       i_clock,
  // register port
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd,
  input  wire logic [7:0] i_rdata
);
  // idle lines at time zero
  initial begin
    o_addr  = 8'hFF;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // one-edge access; lines inverted after so stale values are never trusted
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge i_clock);
    o_addr  = a;
    o_wdata = d;
    o_wr    = w;
    o_rd    = !w;
    @(negedge i_clock);
    q       = i_rdata;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask
  // set go, write the code, poll go until the ramp is over
  task automatic scale(input logic [7:0] ctrl, input logic [7:0] code, output int polls);
    logic [7:0] q;
    acc(1'b1, 8'h01, ctrl | 8'h40, q);
    acc(1'b1, 8'h00, code, q);
    polls = 0;
    q = 8'h40;
    while (q[6] && polls < 2000) begin
      acc(1'b0, 8'h01, 8'h00, q);
      polls++;
    end
  endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the system control block
// assumes the host model owns the register port
`timescale 1ns/1ps
`default_nettype none
module tb import csc_pkg::*;;
  logic       clk, srst, ext, ce, overvoltage_protect, overcurrent_protect, undervoltage_detect, wr, rd, son, hs, ls, pwm, hic, lat;
  logic [7:0] addr, wd, rdat, q;
  logic [6:0] tgt, code;
  int         errors, checks_done, n, polls;
  int         per [8] = '{4, 5, 8, 16, 32, 64, 128, 256};
  logic [9:0] rows [5] = '{10'h299, 10'h29F, 10'h39B, 10'h098, 10'h299};
  csc_sys_ctrl u_dut (.I_CLOCK(clk), .I_SRST(srst), .I_CE(ce), .I_EXT_EN(ext),
    .I_REG_ADDR(addr), .I_REG_WDATA(wd), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdat),
    .O_SERIAL_ON(son), .I_OVERVOLTAGE_PROTECT(overvoltage_protect), .I_OVERCURRENT_PROTECT(overcurrent_protect),
    .I_UNDERVOLTAGE_DETECT(undervoltage_detect), .O_HIGH_SIDE_SWITCH_EN(hs), .O_LOW_SIDE_SWITCH_EN(ls),
    .O_FORCED_PWM(pwm), .O_REF_TARGET(tgt), .O_HICCUP(hic), .O_LATCHED_OFF(lat));
  csc_host u_host (.i_clock(clk), .o_addr(addr), .o_wdata(wd), .o_wr(wr), .o_rd(rd),
    .i_rdata(rdat));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d, q);
  endtask
  task automatic rd8(input logic [7:0] a);
    u_host.acc(1'b0, a, 8'h00, q);
  endtask
  // fault levels change on the falling edge
  task automatic fault(input logic [2:0] f);
    {overvoltage_protect, overcurrent_protect, undervoltage_detect} = f;
    cyc(2);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {srst, ext, ce, overvoltage_protect, overcurrent_protect, undervoltage_detect} = 6'b111000;
    cyc(3);
    srst = 1'b0;
    rd8(SYS_CTRL1_ADDR);
    chk(q, 8'hA6);
    rd8(REF_SELECT_ADDR);
    chk(q, 8'h1E);
    foreach (rows[i]) begin
      wr8(SYS_CTRL1_ADDR, rows[i][9:2]);
      rd8(SYS_CTRL1_ADDR);
      chk(q, rows[i][9:2]);
      chk(pwm, rows[i][1]);
      chk({hs, ls}, {2{rows[i][0]}});
    end
    // a write while the clock enable is low must not land
    ce = 1'b0;
    wr8(SYS_CTRL1_ADDR, 8'h26);
    ce = 1'b1;
    rd8(SYS_CTRL1_ADDR);
    chk(q, 8'hA6);
    code = REF_CODE_RST;
    for (int s = 0; s < 8; s++) begin
      wr8(SYS_CTRL1_ADDR, {2'b11, 3'(s), 3'b110});
      code = code + 7'h01;
      wr8(REF_SELECT_ADDR, {1'b0, code});
      n = 0;
      while (tgt !== code && n < 600) begin
        cyc(1);
        n++;
      end
      chk(n >= per[s] - 1 && n <= per[s] + 3, 1'b1);
      cyc(3);
      rd8(SYS_CTRL1_ADDR);
      chk(q, {2'b10, 3'(s), 3'b110});
      chk(pwm, 1'b0);
    end
    u_host.scale(8'hA6, 8'h2E, polls);
    chk(polls > 1, 1'b1);
    chk(tgt, 8'h2E);
    wr8(REF_SELECT_ADDR, 8'h10);
    cyc(40);
    rd8(REF_SELECT_ADDR);
    chk({q[6:0], tgt}, 14'h172E);
    fault(3'b011);
    chk({hic, hs}, 2'b10);
    fault(3'b000);
    cyc(3986);
    chk(hic, 1'b1);
    cyc(20);
    chk({hic, hs}, 2'b01);
    wr8(SYS_CTRL1_ADDR, 8'hA4);
    fault(3'b011);
    fault(3'b000);
    chk({lat, hs}, 2'b10);
    ext = 1'b0;
    cyc(3);
    chk({son, lat, hs, tgt}, 10'h01E);
    wr8(SYS_CTRL1_ADDR, 8'h06);
    ext = 1'b1;
    rd8(SYS_CTRL1_ADDR);
    chk(q, 8'hA6);
    fault(3'b100);
    chk(hs, 1'b0);
    fault(3'b000);
    chk({lat, hs}, 2'b01);
    wr8(SYS_CTRL1_ADDR, 8'hA2);
    fault(3'b100);
    fault(3'b000);
    chk({lat, hs}, 2'b10);
    srst = 1'b1;
    cyc(1);
    srst = 1'b0;
    chk({lat, hs}, 2'b01);
    summarize();
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule
bind csc_sys_ctrl csc_chk u_chk (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST), .I_CE(I_CE),
  .I_EXT_EN(I_EXT_EN), .I_OVERVOLTAGE_PROTECT(I_OVERVOLTAGE_PROTECT),
  .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR),
  .O_REG_RDATA(O_REG_RDATA), .O_SERIAL_ON(O_SERIAL_ON),
  .O_HIGH_SIDE_SWITCH_EN(O_HIGH_SIDE_SWITCH_EN), .O_LOW_SIDE_SWITCH_EN(O_LOW_SIDE_SWITCH_EN),
  .O_FORCED_PWM(O_FORCED_PWM), .O_REF_TARGET(O_REF_TARGET), .O_HICCUP(O_HICCUP),
  .O_LATCHED_OFF(O_LATCHED_OFF));
`default_nettype wire
